// ===== design/glue_pkg.sv
// Constants shared by the counter clock, interrupt and digital port glue.
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers.
package glue_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_COUNTERS = 12;
  localparam int NUM_SELECTABLE = 10;
  localparam int COUNT_WIDTH = 16;
  localparam int CSTAT_WIDTH = 8;
  localparam int DIO_WIDTH = 8;
  localparam int ADDR_WIDTH = 8;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CLOCK_SELECT_OFF = 8'h00;
  localparam logic [7:0] ROUTING_OFF = 8'h04;
  localparam logic [7:0] IRQ_ENABLE_OFF = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h0C;
  localparam logic [7:0] DOUT_OFF = 8'h10;
  localparam logic [7:0] DIN_OFF = 8'h14;
  localparam logic [7:0] COUNTER_BASE_OFF = 8'h40;
  localparam logic [7:0] COUNTER_LAST_OFF = 8'h6C;

  // ==========================================================
  // Field positions
  localparam int SHARED_SEL_BIT = 0;
  localparam int DEBOUNCE_SEL_BIT = 1;
  localparam int GLOBAL_IRQ_BIT = 2;
  localparam int TIMER_IRQ_BIT = 0;
  localparam int EXT_IRQ_BIT = 1;
  localparam int CSTAT_POS = 16;

  // ==========================================================
  // Reset values
  localparam logic [19:0] CLOCK_SELECT_RST = 20'h00000;
  localparam logic [2:0] ROUTING_RST = 3'h0;
  localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;
  localparam logic [7:0] DOUT_RST = 8'h00;

  // ==========================================================
  // Clock source codes per selectable counter
  typedef enum logic [1:0] {
    SRC_EXT_PIN = 2'h0,
    SRC_PRECEDING = 2'h1,
    SRC_SHARED = 2'h2,
    SRC_TENTH = 2'h3
  } clock_src_t;
endpackage

// ===== design/counter_clock_irq_glue.sv
// Clock routing, dual interrupt and digital port glue for a 12-counter card.
// Assumes the counters sit outside; their outputs, counts and status come in
// on plain ports, synchronous to pclk. Registers are reached over APB.
//
// Operation
// - Counters 1-10 each pick pin, preceding output, shared clock or tenth output.
// - Counter 11 always runs from the fixed 8 MHz reference.
// - Counter 12 always runs from counter 11's output.
// - Shared clock is 8 MHz reference at 0, counter 11 output at 1.
// - Debounce clock is counter 11 output at 0, 2 MHz reference at 1.
// - Interrupt sources are counter 12's output and the external pin.
// - Each source has its own enable bit, 1 enables.
// - Each source has a readable pending flag telling which one fired.
// - Timer request stays latched until software clears it.
// - External request stays latched until its own software clear.
// - A global bit stops the interrupt output regardless of source enables.
// - Eight-bit output port drives the byte software last wrote.
// - Eight-bit input port pin levels are read back as one byte.
// - Software reads count value and status of each of 12 counters.
`timescale 1ns/10ps
module counter_clock_irq_glue
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [glue_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [glue_pkg::NUM_SELECTABLE-1:0] ext_counter_clock_pin,
  input wire logic [glue_pkg::NUM_COUNTERS-1:0] counter_outputs,
  input wire logic fixed_eight_mhz_ref,
  input wire logic fixed_two_mhz_ref,
  input wire logic external_irq_pin,
  input wire logic [glue_pkg::NUM_COUNTERS*glue_pkg::COUNT_WIDTH-1:0] counter_counts,
  input wire logic [glue_pkg::NUM_COUNTERS*glue_pkg::CSTAT_WIDTH-1:0] counter_states,
  input wire logic [glue_pkg::DIO_WIDTH-1:0] digital_in,
  output logic [glue_pkg::DIO_WIDTH-1:0] digital_out,
  output logic [glue_pkg::NUM_COUNTERS-1:0] counter_clocks,
  output logic shared_clock_net,
  output logic debounce_clock_net,
  output logic irq
);
  import glue_pkg::*;

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Unaligned counter offsets count as unmapped
  function automatic logic in_counter_window(input logic [ADDR_WIDTH-1:0] a);
    in_counter_window = (a >= COUNTER_BASE_OFF) && (a <= COUNTER_LAST_OFF)
                        && (a[1:0] == 2'h0);
  endfunction

  function automatic logic pick_clock(input logic [1:0] sel, input logic pin,
                                      input logic prev, input logic shared,
                                      input logic tenth);
    unique case (clock_src_t'(sel))
      SRC_EXT_PIN: pick_clock = pin;
      SRC_PRECEDING: pick_clock = prev;
      SRC_SHARED: pick_clock = shared;
      SRC_TENTH: pick_clock = tenth;
    endcase
  endfunction

  // ==========================================================
  // State
  logic [19:0] counter_clock_select_q;
  logic [2:0] routing_q;
  logic [1:0] irq_enable_q;
  logic [1:0] irq_pending_q;
  logic [DIO_WIDTH-1:0] digital_out_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic [NUM_COUNTERS-1:0] counter_clocks_q;
  logic shared_clock_q;
  logic debounce_clock_q;
  logic [1:0] src_meta_q;
  logic [1:0] src_sync_q;
  logic [1:0] src_last_q;

  // ==========================================================
  // Bus decode
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  // Writes to read-only words land nowhere and raise no error
  wire write_strobe = access_phase & pready_q & pwrite;
  wire sel_clock = hit(paddr, CLOCK_SELECT_OFF);
  wire sel_routing = hit(paddr, ROUTING_OFF);
  wire sel_enable = hit(paddr, IRQ_ENABLE_OFF);
  wire sel_status = hit(paddr, IRQ_STATUS_OFF);
  wire sel_dout = hit(paddr, DOUT_OFF);
  wire sel_din = hit(paddr, DIN_OFF);
  wire sel_counter = in_counter_window(paddr);
  wire [ADDR_WIDTH-1:0] counter_offset = paddr - COUNTER_BASE_OFF;
  wire [3:0] counter_index = counter_offset[5:2];
  wire mapped = sel_clock | sel_routing | sel_enable | sel_status | sel_dout
                | sel_din | sel_counter;

  wire [31:0] counter_words [NUM_COUNTERS];
  genvar c;
  generate
    for (c = 0; c < NUM_COUNTERS; c++)
    begin : g_word
      assign counter_words[c] = {8'h00, counter_states[c*CSTAT_WIDTH +: CSTAT_WIDTH],
                                 counter_counts[c*COUNT_WIDTH +: COUNT_WIDTH]};
    end
  endgenerate
  // Index above 11 never reaches the mux, the window decode stops it
  wire [31:0] counter_word = counter_words[counter_index];

  wire [31:0] clock_word = {12'h000, counter_clock_select_q};
  wire [31:0] routing_word = {29'h00000000, routing_q};
  wire [31:0] enable_word = {30'h00000000, irq_enable_q};
  wire [31:0] status_word = {30'h00000000, irq_pending_q};
  wire [31:0] dout_word = {24'h000000, digital_out_q};
  wire [31:0] din_word = {24'h000000, digital_in};

  wire [31:0] read_mux =
    sel_clock ? clock_word :
    sel_routing ? routing_word :
    sel_enable ? enable_word :
    sel_status ? status_word :
    sel_dout ? dout_word :
    sel_din ? din_word :
    sel_counter ? counter_word : 32'h00000000;

  // ==========================================================
  // APB answer: one wait-free access phase, registered outputs
  wire pready_d = setup_phase;
  wire pslverr_d = setup_phase & ~mapped;
  // Data taken in setup, so a live pin read is one cycle old
  wire [31:0] prdata_d = (setup_phase && !pwrite) ? read_mux : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_q <= 1'b0;
    else
      pready_q <= pready_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_q <= 1'b0;
    else
      pslverr_q <= pslverr_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else
      prdata_q <= prdata_d;
  end

  // ==========================================================
  // Control registers
  wire wr_clock = write_strobe & sel_clock;
  wire wr_routing = write_strobe & sel_routing;
  wire wr_enable = write_strobe & sel_enable;
  wire wr_dout = write_strobe & sel_dout;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      counter_clock_select_q <= CLOCK_SELECT_RST;
    else if (wr_clock)
      counter_clock_select_q <= pwdata[19:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      routing_q <= ROUTING_RST;
    else if (wr_routing)
      routing_q <= pwdata[2:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_enable_q <= IRQ_ENABLE_RST;
    else if (wr_enable)
      irq_enable_q <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      digital_out_q <= DOUT_RST;
    else if (wr_dout)
      digital_out_q <= pwdata[DIO_WIDTH-1:0];
  end

  // ==========================================================
  // Interrupt sources
  // timer and external sources
  wire [1:0] src_raw = {external_irq_pin, counter_outputs[NUM_COUNTERS-1]};

  // rising edge latches before enables
  // Edge detect keeps a pin held high from re-raising after a clear
  wire [1:0] src_rise = src_sync_q & ~src_last_q;
  wire wr_status = write_strobe & sel_status;
  wire [1:0] clear_bits = wr_status ? pwdata[1:0] : 2'h0;
  // Set beats clear so an edge in the clear cycle survives
  wire [1:0] irq_pending_d = (irq_pending_q & ~clear_bits) | src_rise;

  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_src
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          src_meta_q[s] <= 1'b0;
          src_sync_q[s] <= 1'b0;
          src_last_q[s] <= 1'b0;
        end
        else
        begin
          src_meta_q[s] <= src_raw[s];
          src_sync_q[s] <= src_meta_q[s];
          src_last_q[s] <= src_sync_q[s];
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          irq_pending_q[s] <= 1'b0;
        else
          irq_pending_q[s] <= irq_pending_d[s];
      end
    end
  endgenerate

  wire irq_any = |(irq_pending_q & irq_enable_q);
  wire irq_d = routing_q[GLOBAL_IRQ_BIT] & irq_any;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  // ==========================================================
  // Clock routing
  // shared clock choice
  wire shared_d = routing_q[SHARED_SEL_BIT] ? counter_outputs[10] : fixed_eight_mhz_ref;
  wire debounce_d = routing_q[DEBOUNCE_SEL_BIT] ? fixed_two_mhz_ref : counter_outputs[10];

  wire [NUM_COUNTERS-1:0] counter_clocks_d;
  // Counter 1 has no predecessor, its preceding choice reads low
  wire [NUM_SELECTABLE-1:0] preceding = {counter_outputs[NUM_SELECTABLE-2:0], 1'b0};

  genvar g;
  generate
    for (g = 0; g < NUM_SELECTABLE; g++)
    begin : g_sel
      assign counter_clocks_d[g] = pick_clock(counter_clock_select_q[2*g +: 2],
                                              ext_counter_clock_pin[g], preceding[g],
                                              shared_d, counter_outputs[9]);
    end
  endgenerate

  assign counter_clocks_d[10] = fixed_eight_mhz_ref;
  assign counter_clocks_d[11] = counter_outputs[10];

  // Registered routing adds one pclk of delay; fine at these rates
  // Reference levels are sampled, so pclk must run well above them
  genvar r;
  generate
    for (r = 0; r < NUM_COUNTERS; r++)
    begin : g_route
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          counter_clocks_q[r] <= 1'b0;
        else
          counter_clocks_q[r] <= counter_clocks_d[r];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shared_clock_q <= 1'b0;
    else
      shared_clock_q <= shared_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      debounce_clock_q <= 1'b0;
    else
      debounce_clock_q <= debounce_d;
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign digital_out = digital_out_q;
  assign counter_clocks = counter_clocks_q;
  assign shared_clock_net = shared_clock_q;
  assign debounce_clock_net = debounce_clock_q;
  assign irq = irq_q;
endmodule

// ===== sim/glue_checker.sv
// Port relations of the clock routing and interrupt glue.
// Assumes it is bound into the top glue module.
`timescale 1ns/10ps
module glue_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [glue_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [glue_pkg::NUM_COUNTERS-1:0] counter_outputs,
  input wire logic fixed_eight_mhz_ref,
  input wire logic fixed_two_mhz_ref,
  input wire logic [glue_pkg::DIO_WIDTH-1:0] digital_in,
  input wire logic [glue_pkg::DIO_WIDTH-1:0] digital_out,
  input wire logic [glue_pkg::NUM_COUNTERS-1:0] counter_clocks,
  input wire logic shared_clock_net,
  input wire logic debounce_clock_net,
  input wire logic irq
);
  import glue_pkg::*;
  // ==========================================
  // Relations
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  property p_dout;
    wr_done && paddr == DOUT_OFF |=> digital_out == $past(pwdata[7:0]);
  endproperty
  a_dout: assert property (p_dout) else $error("output port not the written byte");
  property p_din;
    psel && !penable && !pwrite && paddr == DIN_OFF |=> prdata == {24'h000000, $past(digital_in)};
  endproperty
  a_din: assert property (p_din) else $error("input port read wrong");
  property p_clk11;
    $past(presetn) |-> counter_clocks[10] == $past(fixed_eight_mhz_ref);
  endproperty
  a_clk11: assert property (p_clk11) else $error("counter 11 clock wrong");
  property p_clk12;
    $past(presetn) |-> counter_clocks[11] == $past(counter_outputs[10]);
  endproperty
  a_clk12: assert property (p_clk12) else $error("counter 12 clock wrong");
  property p_shared;
    $past(presetn) |-> shared_clock_net == $past(fixed_eight_mhz_ref)
      || shared_clock_net == $past(counter_outputs[10]);
  endproperty
  a_shared: assert property (p_shared) else $error("shared clock source wrong");
  property p_dbnc;
    $past(presetn) |-> debounce_clock_net == $past(fixed_two_mhz_ref)
      || debounce_clock_net == $past(counter_outputs[10]);
  endproperty
  a_dbnc: assert property (p_dbnc) else $error("debounce clock source wrong");
  property p_glb;
    wr_done && paddr == ROUTING_OFF && !pwdata[GLOBAL_IRQ_BIT] |-> ##2 !irq;
  endproperty
  a_glb: assert property (p_glb) else $error("irq high with global off");
  property p_en;
    wr_done && paddr == IRQ_ENABLE_OFF && pwdata[1:0] == 2'h0 |-> ##2 !irq;
  endproperty
  a_en: assert property (p_en) else $error("irq high with sources off");
endmodule
bind counter_clock_irq_glue glue_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .paddr, .pwdata, .prdata, .counter_outputs, .fixed_eight_mhz_ref,
  .fixed_two_mhz_ref, .digital_in, .digital_out, .counter_clocks, .shared_clock_net,
  .debounce_clock_net, .irq);

// ===== sim/counter_bank_model.sv
// Behavioural bank of twelve counters giving counts and status words.
// Assumes bench clock and reset; counts only while run is high.
`timescale 1ns/10ps
module counter_bank_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic [glue_pkg::NUM_COUNTERS*glue_pkg::COUNT_WIDTH-1:0] counts,
  output logic [glue_pkg::NUM_COUNTERS*glue_pkg::CSTAT_WIDTH-1:0] states
);
  import glue_pkg::*;
  // ==========================================
  // Down counters, each at its own rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    for (int i = 0; i < NUM_COUNTERS; i++)
    begin
      if (!presetn)
      begin
        counts[i*16 +: 16] <= 16'hFFFF - 16'(i) * 16'h0111;
        states[i*8 +: 8] <= 8'(i) ^ 8'hA5;
      end
      else if (run)
      begin
        counts[i*16 +: 16] <= counts[i*16 +: 16] - 16'(i + 1);
        states[i*8 +: 8] <= states[i*8 +: 8] ^ 8'h80;
      end
    end
  end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the counter clock and interrupt glue.
// Assumes the glue package and the counter bank model beside the design.
`timescale 1ns/10ps
module tb_top;
  import glue_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic fixed_eight_mhz_ref = 1'b0, fixed_two_mhz_ref = 1'b0, external_irq_pin = 1'b0;
  logic pready, pslverr, irq, shared_clock_net, debounce_clock_net, e, sh;
  logic [7:0] paddr = 8'h00, digital_in = 8'h00, digital_out;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic [9:0] ext_counter_clock_pin = 10'h000;
  logic [11:0] counter_outputs = 12'h000, counter_clocks;
  logic [191:0] counter_counts;
  logic [95:0] counter_states;
  int num_errors = 0, n_checks = 0, seed = 99351, k;
  always #20 pclk = ~pclk;
  counter_clock_irq_glue dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_counter_clock_pin, .counter_outputs, .fixed_eight_mhz_ref,
    .fixed_two_mhz_ref, .external_irq_pin, .counter_counts, .counter_states, .digital_in,
    .digital_out, .counter_clocks, .shared_clock_net, .debounce_clock_net, .irq);
  counter_bank_model bank (.pclk, .presetn, .run, .counts(counter_counts),
    .states(counter_states));
  // ==========================================
  // Tasks
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      $display("ERROR %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask
  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (t >= 20)
    begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read data", x, rd);
  endtask
  task automatic irq_wait(input logic v);
    for (int t = 0; t < 10 && irq !== v; t++)
      @(posedge pclk);
    chk("irq", 32'(v), 32'(irq));
  endtask
  function automatic logic [11:0] exp_clocks(input logic [1:0] code, input logic s);
    logic [11:0] c;
    c[10] = fixed_eight_mhz_ref;
    c[11] = counter_outputs[10];
    for (int i = 0; i < 10; i++)
      case (code)
        SRC_EXT_PIN: c[i] = ext_counter_clock_pin[i];
        SRC_PRECEDING: c[i] = (i == 0) ? 1'b0 : counter_outputs[i-1];
        SRC_SHARED: c[i] = s;
        default: c[i] = counter_outputs[9];
      endcase
    return c;
  endfunction
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 5; k++)
      rchk(8'(k * 4), 32'h0);
    chk("digital_out", 32'h0, 32'(digital_out));
    for (k = 0; k < 4; k++)
    begin
      d = $random(seed);
      apb(1'b1, DOUT_OFF, d);
      chk("digital_out", 32'(d[7:0]), 32'(digital_out));
      digital_in <= d[15:8];
      rchk(DIN_OFF, 32'(d[15:8]));
    end
    apb(1'b0, 8'hFC, 32'h0);
    chk("pslverr", 32'h1, 32'(e));
    run <= 1'b1;
    repeat (($random(seed) & 63) + 1) @(posedge pclk);
    run <= 1'b0;
    @(posedge pclk);
    for (k = 0; k < NUM_COUNTERS; k++)
      rchk(COUNTER_BASE_OFF + 8'(k * 4), {8'h00, counter_states[k*8 +: 8], counter_counts[k*16 +: 16]});
    for (k = 0; k < 4; k++)
    begin
      d = $random(seed);
      apb(1'b1, CLOCK_SELECT_OFF, {12'h000, {10{2'(k)}}});
      apb(1'b1, ROUTING_OFF, {30'h0, d[1:0]});
      ext_counter_clock_pin <= d[17:8];
      counter_outputs[10:0] <= d[28:18];
      fixed_eight_mhz_ref <= d[29];
      fixed_two_mhz_ref <= d[30];
      repeat (4) @(posedge pclk);
      sh = d[0] ? d[28] : d[29];
      chk("counter_clocks", 32'(exp_clocks(2'(k), sh)), 32'(counter_clocks));
      chk("shared_clock_net", 32'(sh), 32'(shared_clock_net));
      chk("debounce_clock_net", 32'(d[1] ? d[30] : d[28]), 32'(debounce_clock_net));
    end
    apb(1'b1, IRQ_STATUS_OFF, 32'h3);
    apb(1'b1, IRQ_ENABLE_OFF, 32'h1);
    apb(1'b1, ROUTING_OFF, 32'h4);
    counter_outputs[11] <= 1'b1;
    irq_wait(1'b1);
    rchk(IRQ_STATUS_OFF, 32'h1);
    counter_outputs[11] <= 1'b0;
    repeat (3) @(posedge pclk);
    counter_outputs[11] <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, IRQ_STATUS_OFF, 32'h1);
    irq_wait(1'b0);
    external_irq_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(IRQ_STATUS_OFF, 32'h2);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, IRQ_ENABLE_OFF, 32'h2);
    irq_wait(1'b1);
    apb(1'b1, ROUTING_OFF, 32'h0);
    irq_wait(1'b0);
    apb(1'b1, ROUTING_OFF, 32'h4);
    irq_wait(1'b1);
    apb(1'b1, IRQ_STATUS_OFF, 32'h2);
    irq_wait(1'b0);
    apb(1'b1, IRQ_ENABLE_OFF, 32'h0);
    conclude();
  end
endmodule
